// ===== hdl/stk_pkg.sv
// Shared constants and types for the stack instruction unit.
`default_nettype none
package stk_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int ADDR_W = 15;
	localparam int CELL_W = 3;

	// ------------------------------------------------------------------
	// Status word layout and word counts
	// ------------------------------------------------------------------
	localparam int             STAT_OVF_BIT   = 0;
	localparam int             STAT_BYTE_BIT  = 1;
	localparam logic [15:0]    STAT_SW_MASK   = 16'hff00;
	localparam int             SIGN_BIT       = 15;
	localparam logic [2:0]     MAX_CELLS_REGS = 3'h4;
	localparam logic [2:0]     MAX_CELLS_STAT = 3'h6;
	localparam logic [2:0]     WORDS_REGS     = 3'h4;
	localparam logic [2:0]     WORDS_STAT     = 3'h2;
	localparam logic [15:0]    ONE_WORD       = 16'h0001;
	localparam logic [14:0]    ONE_ADDR       = 15'h0001;
	localparam logic [1:0]     IDX_X          = 2'h0;
	localparam logic [1:0]     IDX_A          = 2'h1;
	localparam logic [1:0]     IDX_ST         = 2'h2;
	localparam logic [1:0]     IDX_P          = 2'h3;

	// ------------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_READ  = 3'b000,
		OP_WRITE = 3'b001,
		OP_JPR   = 3'b010,
		OP_JPS   = 3'b011,
		OP_RPR   = 3'b100,
		OP_RPS   = 3'b101
	} stk_op_type;

	typedef enum logic [1:0] {
		MODE_DIRECT  = 2'b00,
		MODE_INDEXED = 2'b01,
		MODE_POP     = 2'b10,
		MODE_PUSH    = 2'b11
	} stk_mode_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_IND  = 3'b001,
		ST_PTR  = 3'b010,
		ST_PRE  = 3'b011,
		ST_ELEM = 3'b100,
		ST_POST = 3'b101,
		ST_XFER = 3'b110
	} stk_state_type;

endpackage
`default_nettype wire

// ===== hdl/stk_addr_calc.sv
// Element address former for the four addressing modes.
`timescale 1ns/1ns
`default_nettype none
module stk_addr_calc #(
	parameter int W  = 16,
	parameter int AW = 15
) (
	input  wire logic [W-1:0]         ptr_word,
	input  wire logic [W-1:0]         index,
	input  wire stk_pkg::stk_mode_type mode,
	output logic      [AW-1:0]        elem_addr
);
	logic [W-1:0] sum;

	// ------------------------------------------------------------------
	// Address forming
	// ------------------------------------------------------------------
	// The signed sum wraps naturally; dropping the top bit forces it low.
	always_comb begin
		sum = ptr_word + index;
		if (mode == stk_pkg::MODE_INDEXED) begin
			elem_addr = sum[AW-1:0];
		end else begin
			elem_addr = ptr_word[AW-1:0];
		end
	end
endmodule // stk_addr_calc
`default_nettype wire

// ===== hdl/stk_mem_port.sv
// One-access-at-a-time request and acknowledge port toward main memory.
`timescale 1ns/1ns
`default_nettype none
module stk_mem_port #(
	parameter int W  = 16,
	parameter int AW = 15
) (
	input  wire logic          sys_clk,
	input  wire logic          rst,
	input  wire logic          issue,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [W-1:0]  mem_rdata,
	input  wire logic          mem_ack,
	output logic               mem_req,
	output logic               mem_we,
	output logic      [AW-1:0] mem_addr,
	output logic      [W-1:0]  mem_wdata,
	output logic               port_done,
	output logic      [W-1:0]  port_rdata
);
	logic          next_req;
	logic          next_we;
	logic [AW-1:0] next_addr;
	logic [W-1:0]  next_wdata;
	logic          next_done;
	logic [W-1:0]  next_rdata;

	always_comb begin
		next_req   = mem_req;
		next_we    = mem_we;
		next_addr  = mem_addr;
		next_wdata = mem_wdata;
		next_done  = 1'b0;
		next_rdata = port_rdata;
		if (issue) begin
			next_req   = 1'b1;
			next_we    = we;
			next_addr  = addr;
			next_wdata = wdata;
		end else if (mem_req && mem_ack) begin
			next_req   = 1'b0;
			next_done  = 1'b1;
			next_rdata = mem_rdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mem_req    <= 1'b0;
			mem_we     <= 1'b0;
			mem_addr   <= '0;
			mem_wdata  <= '0;
			port_done  <= 1'b0;
			port_rdata <= '0;
		end else begin
			mem_req    <= next_req;
			mem_we     <= next_we;
			mem_addr   <= next_addr;
			mem_wdata  <= next_wdata;
			port_done  <= next_done;
			port_rdata <= next_rdata;
		end
	end
endmodule // stk_mem_port
`default_nettype wire

// ===== hdl/stk_unit.sv
// Stack instruction execution unit: pointer fetch, element access, calls.
// What this block does
// - Stacks up to 32,768 whole words, last-in-first-out, starting anywhere.
// - Stacks grow downward; a push lands below the previous top entry.
// - Every access is a full word; byte mode is ignored.
// - Second instruction word is the absolute address of the pointer.
// - Base model drops bit 15 of addresses; indexing keeps the sign.
// - Extended model follows multilevel indirection of the pointer address.
// - Call and return instructions never use indirection.
// - Direct mode uses the fetched pointer itself as element address.
// - Indexed mode adds signed index and forces bit 15 low.
// - Pop accesses at pointer, then writes back pointer plus one.
// - Push writes back pointer minus one, then accesses there.
// - Register call pushes index, accumulator, status, return address.
// - Both calls clear the overflow and byte mode flags.
// - Calls jump to one above the pointer address word.
// - A call used as interrupt instruction clears interrupt enable.
// - Status call pushes only status and return address.
// - Register return pops return address, status, accumulator, index.
// - Return enables interrupts, loads flags, keeps switch bits.
// - Status return pops only return address and status.
// - Temporary cells: at most four for registers, six for status.
// - Temporary cells sit above saved words and are never touched.
`timescale 1ns/1ns
`default_nettype none
module stk_unit #(
	parameter int W  = stk_pkg::WORD_W,
	parameter int AW = stk_pkg::ADDR_W,
	parameter int CW = stk_pkg::CELL_W
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic                  start,
	input  wire stk_pkg::stk_op_type   op_kind,
	input  wire stk_pkg::stk_mode_type addressing_mode_operand,
	input  wire logic                  indirect,
	input  wire logic                  ext_model,
	input  wire logic                  int_instr,
	input  wire logic [CW-1:0]         temp_cell_count,
	input  wire logic [W-1:0]          pointer_address_word,
	input  wire logic [W-1:0]          index_reg,
	input  wire logic [W-1:0]          acc_reg,
	input  wire logic [W-1:0]          status_reg,
	input  wire logic [W-1:0]          pc_reg,
	input  wire logic [W-1:0]          elem_wdata,
	input  wire logic [W-1:0]          mem_rdata,
	input  wire logic                  mem_ack,
	output logic                       busy,
	output logic                       done,
	output logic      [W-1:0]          elem_data,
	output logic      [AW-1:0]         element_address,
	output logic      [W-1:0]          pc_out,
	output logic      [W-1:0]          status_out,
	output logic      [W-1:0]          acc_out,
	output logic      [W-1:0]          index_out,
	output logic                       int_enable,
	output logic                       mem_req,
	output logic                       mem_we,
	output logic      [AW-1:0]         mem_addr,
	output logic      [W-1:0]          mem_wdata
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	stk_pkg::stk_state_type state, next_state;
	stk_pkg::stk_op_type    op, next_op;
	stk_pkg::stk_mode_type  mode, next_mode;
	logic          sent, next_sent;
	logic          intr, next_intr;
	logic [CW-1:0] cell_req, next_cell_req;
	logic [CW-1:0] k, next_k;
	logic [AW-1:0] ptr_loc, next_ptr_loc;
	logic [W-1:0]  ptr, next_ptr;
	logic [W-1:0]  xr, next_xr;
	logic [W-1:0]  ar, next_ar;
	logic [W-1:0]  sr, next_sr;
	logic [W-1:0]  pr, next_pr;
	logic [W-1:0]  wd, next_wd;
	logic          next_busy, next_done, next_ie;
	logic [W-1:0]  next_elem_data, next_pc, next_status;
	logic [W-1:0]  next_acc, next_index;
	logic [AW-1:0] next_elem_addr;

	logic          issue, is_call, is_ret, is_regs, is_elem, last_word;
	logic          p_we;
	logic [AW-1:0] p_addr;
	logic [W-1:0]  p_wdata, new_ptr, push_addr, save_word;
	logic [CW-1:0] words, cells;
	logic [1:0]    save_idx;
	logic [AW-1:0] calc_addr;
	logic          port_done;
	logic [W-1:0]  port_rdata;

	stk_addr_calc #(.W(W), .AW(AW)) u_calc (
		.ptr_word  (ptr),
		.index     (xr),
		.mode      (mode),
		.elem_addr (calc_addr)
	);

	stk_mem_port #(.W(W), .AW(AW)) u_port (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.issue      (issue),
		.we         (p_we),
		.addr       (p_addr),
		.wdata      (p_wdata),
		.mem_rdata  (mem_rdata),
		.mem_ack    (mem_ack),
		.mem_req    (mem_req),
		.mem_we     (mem_we),
		.mem_addr   (mem_addr),
		.mem_wdata  (mem_wdata),
		.port_done  (port_done),
		.port_rdata (port_rdata)
	);

	// ------------------------------------------------------------------
	// Decode and access forming
	// ------------------------------------------------------------------
	// Counts above the limit saturate, so a bad count cannot reach cells
	// belonging to the caller's frame.
	always_comb begin
		is_call = (op == stk_pkg::OP_JPR) || (op == stk_pkg::OP_JPS);
		is_ret  = (op == stk_pkg::OP_RPR) || (op == stk_pkg::OP_RPS);
		is_regs = (op == stk_pkg::OP_JPR) || (op == stk_pkg::OP_RPR);
		is_elem = !is_call && !is_ret;
		words   = is_regs ? stk_pkg::WORDS_REGS : stk_pkg::WORDS_STAT;
		cells   = cell_req;
		if (is_regs && cell_req > stk_pkg::MAX_CELLS_REGS) begin
			cells = stk_pkg::MAX_CELLS_REGS;
		end else if (!is_regs && cell_req > stk_pkg::MAX_CELLS_STAT) begin
			cells = stk_pkg::MAX_CELLS_STAT;
		end
		last_word = (k == words - 3'(1));
		// Saved words go below the cells, never into them.
		push_addr = ptr - W'(cells) - W'(k) - stk_pkg::ONE_WORD;
		save_idx  = is_regs ? k[1:0] : 2'(k + stk_pkg::WORDS_STAT);
		case (save_idx)
			stk_pkg::IDX_X:  save_word = xr;
			stk_pkg::IDX_A:  save_word = ar;
			stk_pkg::IDX_ST: save_word = sr;
			default:         save_word = pr;
		endcase
		if (is_call) begin
			new_ptr = ptr - W'(cells) - W'(words);
		end else if (is_ret) begin
			new_ptr = ptr + W'(cells) + W'(words);
		end else begin
			new_ptr = ptr + stk_pkg::ONE_WORD;
		end
		issue   = (state != stk_pkg::ST_IDLE) && !sent;
		p_we    = 1'b0;
		p_addr  = ptr_loc;
		p_wdata = new_ptr;
		case (state)
			stk_pkg::ST_PRE: begin
				p_we    = 1'b1;
				p_wdata = ptr - stk_pkg::ONE_WORD;
			end
			stk_pkg::ST_ELEM: begin
				p_we    = (op == stk_pkg::OP_WRITE);
				p_addr  = calc_addr;
				p_wdata = wd;
			end
			stk_pkg::ST_POST: begin
				p_we = 1'b1;
			end
			stk_pkg::ST_XFER: begin
				p_we    = is_call;
				p_addr  = is_call ? push_addr[AW-1:0] : AW'(ptr + W'(k));
				p_wdata = save_word;
			end
			default: begin
				p_we = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always_comb begin
		next_state     = state;
		next_op        = op;
		next_mode      = mode;
		next_sent      = issue ? 1'b1 : (port_done ? 1'b0 : sent);
		next_intr      = intr;
		next_cell_req  = cell_req;
		next_k         = k;
		next_ptr_loc   = ptr_loc;
		next_ptr       = ptr;
		next_xr        = xr;
		next_ar        = ar;
		next_sr        = sr;
		next_pr        = pr;
		next_wd        = wd;
		next_busy      = busy;
		next_done      = 1'b0;
		next_ie        = int_enable;
		next_elem_data = elem_data;
		next_elem_addr = element_address;
		next_pc        = pc_out;
		next_status    = status_out;
		next_acc       = acc_out;
		next_index     = index_out;
		case (state)
			stk_pkg::ST_IDLE: begin
				if (start) begin
					next_op   = op_kind;
					next_mode = addressing_mode_operand;
					next_intr = int_instr;
					next_cell_req = temp_cell_count;
					next_ptr_loc = pointer_address_word[AW-1:0];
					next_xr   = index_reg;
					next_ar   = acc_reg;
					next_sr   = status_reg;
					next_pr   = pc_reg;
					next_wd   = elem_wdata;
					next_busy = 1'b1;
					next_k    = '0;
					if (indirect && ext_model && op_kind != stk_pkg::OP_JPR
						&& op_kind != stk_pkg::OP_JPS
						&& op_kind != stk_pkg::OP_RPR
						&& op_kind != stk_pkg::OP_RPS) begin
						next_state = stk_pkg::ST_IND;
					end else begin
						next_state = stk_pkg::ST_PTR;
					end
				end
			end
			stk_pkg::ST_IND: begin
				if (port_done) begin
					next_ptr_loc = port_rdata[AW-1:0];
					if (!port_rdata[stk_pkg::SIGN_BIT]) begin
						next_state = stk_pkg::ST_PTR;
					end
				end
			end
			stk_pkg::ST_PTR: begin
				if (port_done) begin
					// Full word kept so a set top bit still indexes as negative.
					next_ptr = port_rdata;
					if (!is_elem) begin
						next_state = stk_pkg::ST_XFER;
					end else if (mode == stk_pkg::MODE_PUSH) begin
						next_state = stk_pkg::ST_PRE;
					end else begin
						next_state = stk_pkg::ST_ELEM;
					end
				end
			end
			stk_pkg::ST_PRE: begin
				if (port_done) begin
					next_ptr   = ptr - stk_pkg::ONE_WORD;
					next_state = stk_pkg::ST_ELEM;
				end
			end
			stk_pkg::ST_ELEM: begin
				if (port_done) begin
					next_elem_addr = calc_addr;
					if (op == stk_pkg::OP_READ) begin
						next_elem_data = port_rdata;
					end
					if (mode == stk_pkg::MODE_POP) begin
						next_state = stk_pkg::ST_POST;
					end else begin
						next_state = stk_pkg::ST_IDLE;
						next_busy  = 1'b0;
						next_done  = 1'b1;
					end
				end
			end
			stk_pkg::ST_XFER: begin
				if (port_done) begin
					next_k = k + 3'(1);
					if (is_ret) begin
						case (k[1:0])
							stk_pkg::IDX_X: next_pr = port_rdata;
							stk_pkg::IDX_A: next_sr = port_rdata;
							stk_pkg::IDX_ST: next_ar = port_rdata;
							default: next_xr = port_rdata;
						endcase
					end
					if (last_word) begin
						next_state = stk_pkg::ST_POST;
					end
				end
			end
			stk_pkg::ST_POST: begin
				if (port_done) begin
					next_state = stk_pkg::ST_IDLE;
					next_busy  = 1'b0;
					next_done  = 1'b1;
					next_ptr   = new_ptr;
					next_pc    = pr;
					next_status = sr;
					next_acc   = ar;
					next_index = xr;
					if (is_call) begin
						next_pc = W'(ptr_loc) + stk_pkg::ONE_WORD;
						next_status[stk_pkg::STAT_OVF_BIT]  = 1'b0;
						next_status[stk_pkg::STAT_BYTE_BIT] = 1'b0;
						if (intr) begin
							next_ie = 1'b0;
						end
					end else if (is_ret) begin
						next_ie = 1'b1;
						next_status = (sr & ~stk_pkg::STAT_SW_MASK)
							| (status_reg & stk_pkg::STAT_SW_MASK);
					end
				end
			end
			default: begin
				next_state = stk_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state           <= stk_pkg::ST_IDLE;
			op              <= stk_pkg::OP_READ;
			mode            <= stk_pkg::MODE_DIRECT;
			sent            <= 1'b0;
			intr            <= 1'b0;
			cell_req        <= '0;
			k               <= '0;
			ptr_loc         <= '0;
			ptr             <= '0;
			xr              <= '0;
			ar              <= '0;
			sr              <= '0;
			pr              <= '0;
			wd              <= '0;
			busy            <= 1'b0;
			done            <= 1'b0;
			int_enable      <= 1'b0;
			elem_data       <= '0;
			element_address <= '0;
			pc_out          <= '0;
			status_out      <= '0;
			acc_out         <= '0;
			index_out       <= '0;
		end else begin
			state           <= next_state;
			op              <= next_op;
			mode            <= next_mode;
			sent            <= next_sent;
			intr            <= next_intr;
			cell_req        <= next_cell_req;
			k               <= next_k;
			ptr_loc         <= next_ptr_loc;
			ptr             <= next_ptr;
			xr              <= next_xr;
			ar              <= next_ar;
			sr              <= next_sr;
			pr              <= next_pr;
			wd              <= next_wd;
			busy            <= next_busy;
			done            <= next_done;
			int_enable      <= next_ie;
			elem_data       <= next_elem_data;
			element_address <= next_elem_addr;
			pc_out          <= next_pc;
			status_out      <= next_status;
			acc_out         <= next_acc;
			index_out       <= next_index;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_push_below;
		mem_req && mem_we && state == stk_pkg::ST_XFER && ptr > 16'h0010
			|-> W'(mem_addr) < ptr;
	endproperty
	a_push_below: assert property (p_push_below)
		else $error("call word not below pointer");

	property p_direct_addr;
		mem_req && state == stk_pkg::ST_ELEM
			&& mode != stk_pkg::MODE_INDEXED |-> mem_addr == ptr[AW-1:0];
	endproperty
	a_direct_addr: assert property (p_direct_addr)
		else $error("element address differs from pointer");

	property p_index_addr;
		mem_req && state == stk_pkg::ST_ELEM
			&& mode == stk_pkg::MODE_INDEXED
			|-> mem_addr == 15'(ptr + xr);
	endproperty
	a_index_addr: assert property (p_index_addr)
		else $error("indexed address wrong");

	property p_pre_dec;
		mem_req && state == stk_pkg::ST_PRE |-> mem_we
			&& mem_wdata == ptr - stk_pkg::ONE_WORD && mem_addr == ptr_loc;
	endproperty
	a_pre_dec: assert property (p_pre_dec)
		else $error("push writeback wrong");

	property p_post_inc;
		mem_req && state == stk_pkg::ST_POST && is_elem
			|-> mem_we && mem_wdata == ptr + stk_pkg::ONE_WORD;
	endproperty
	a_post_inc: assert property (p_post_inc)
		else $error("pop writeback wrong");

	property p_call_flags;
		state == stk_pkg::ST_POST && port_done && is_call
			|=> done && !status_out[stk_pkg::STAT_OVF_BIT]
			&& !status_out[stk_pkg::STAT_BYTE_BIT]
			&& pc_out == W'($past(ptr_loc)) + stk_pkg::ONE_WORD;
	endproperty
	a_call_flags: assert property (p_call_flags)
		else $error("call flags or jump target wrong");

	property p_call_first;
		mem_req && mem_we && state == stk_pkg::ST_XFER && k == '0
			&& op == stk_pkg::OP_JPR |-> mem_wdata == xr;
	endproperty
	a_call_first: assert property (p_call_first)
		else $error("register call does not save index first");

	property p_ret_ie;
		state == stk_pkg::ST_POST && port_done && is_ret
			|=> int_enable && done [*1] ##1 !done;
	endproperty
	a_ret_ie: assert property (p_ret_ie)
		else $error("return did not enable interrupts");

	property p_ptr_move;
		mem_req && state == stk_pkg::ST_POST && is_call
			|-> mem_wdata == ptr - W'(cells) - W'(words);
	endproperty
	a_ptr_move: assert property (p_ptr_move)
		else $error("call pointer move wrong");

	property p_no_ind_call;
		state == stk_pkg::ST_IND |-> is_elem;
	endproperty
	a_no_ind_call: assert property (p_no_ind_call)
		else $error("call or return used indirection");

	c_call_regs: cover property (done && $past(op) == stk_pkg::OP_JPR);
	c_ret_stat: cover property (done && $past(op) == stk_pkg::OP_RPS);
	c_push: cover property (state == stk_pkg::ST_PRE && port_done);
	c_indir: cover property (state == stk_pkg::ST_IND ##1
		state == stk_pkg::ST_IND);

endmodule // stk_unit
`default_nettype wire

// ===== verif/stk_mem.sv
// Word-addressed memory model answering the stack unit's requests.
`timescale 1ns/1ns
`default_nettype none
module stk_mem (
	input  wire logic        sys_clk,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [14:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	input  wire logic [3:0]  lat,
	output logic             mem_ack,
	output logic      [15:0] mem_rdata
);
	// ----------
	// Storage
	// ----------
	logic [15:0] mem [0:32767];
	logic [15:0] last = 16'h0000;
	logic [3:0]  wait_ticks = 4'h0;
	assign mem_ack = mem_req && (wait_ticks >= lat);
	// Data lines toggle between answers so a stale word never passes.
	assign mem_rdata = mem_ack ? mem[mem_addr] : ~last;
	always @(posedge sys_clk) begin
		last <= mem_rdata;
		if (mem_ack) begin
			wait_ticks <= 4'h0;
			if (mem_we)
				mem[mem_addr] <= mem_wdata;
		end else if (mem_req)
			wait_ticks <= wait_ticks + 4'h1;
	end
endmodule // stk_mem
`default_nettype wire

// ===== verif/test_stk_unit.sv
// Directed tests of the stack unit against a memory model.
`timescale 1ns/1ns
`default_nettype none
module test_stk_unit;
	// ----------
	// Signals
	// ----------
	logic                  sys_clk, rst, start, indirect, ext_model;
	logic                  int_instr, mem_ack, busy, done, int_enable;
	logic                  mem_req, mem_we;
	stk_pkg::stk_op_type   op_kind;
	stk_pkg::stk_mode_type addressing_mode_operand;
	logic [2:0]            temp_cell_count;
	logic [3:0]            lat;
	logic [15:0]           pointer_address_word, index_reg, acc_reg;
	logic [15:0]           status_reg, pc_reg, elem_wdata, mem_rdata;
	logic [15:0]           elem_data, pc_out, status_out, acc_out;
	logic [15:0]           index_out, mem_wdata;
	logic [14:0]           element_address, mem_addr;
	int                    n_fail = 0;
	int                    checks = 0;
	stk_unit u_stk_unit (.sys_clk, .rst, .start, .op_kind,
		.addressing_mode_operand, .indirect, .ext_model, .int_instr,
		.temp_cell_count, .pointer_address_word, .index_reg, .acc_reg,
		.status_reg, .pc_reg, .elem_wdata, .mem_rdata, .mem_ack, .busy,
		.done, .elem_data, .element_address, .pc_out, .status_out,
		.acc_out, .index_out, .int_enable, .mem_req, .mem_we, .mem_addr,
		.mem_wdata);
	stk_mem u_stk_mem (.sys_clk, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .lat, .mem_ack, .mem_rdata);
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// ----------
	// Tasks
	// ----------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Called just after a rising edge; returns just after one.
	task automatic go(input stk_pkg::stk_op_type o,
		input stk_pkg::stk_mode_type m, input logic [2:0] c, input int t);
		int i;
		op_kind <= o;
		addressing_mode_operand <= m;
		temp_cell_count <= c;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		for (i = 0; i < 200; i++) begin
			@(negedge sys_clk);
			if (done === 1'b1)
				break;
		end
		if (i == 200)
			n_fail++;
		@(posedge sys_clk);
		$display("test %0d done", t);
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		conclude();
	end
	// ----------
	// Tests
	// ----------
	initial begin
		rst = 1'b1;
		start = 1'b0;
		indirect = 1'b0;
		ext_model = 1'b0;
		int_instr = 1'b0;
		op_kind = stk_pkg::OP_READ;
		addressing_mode_operand = stk_pkg::MODE_DIRECT;
		temp_cell_count = 3'h0;
		lat = 4'h0;
		pointer_address_word = 16'h0100;
		index_reg = 16'h0000;
		acc_reg = 16'h0000;
		status_reg = 16'h0000;
		pc_reg = 16'h0000;
		elem_wdata = 16'h1234;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		u_stk_mem.mem[15'h0100] = 16'h0200;
		go(stk_pkg::OP_WRITE, stk_pkg::MODE_PUSH, 3'h0, 1);
		chk(u_stk_mem.mem[15'h0100], 16'h01ff);
		chk(u_stk_mem.mem[15'h01ff], 16'h1234);
		lat <= 4'h3;
		go(stk_pkg::OP_READ, stk_pkg::MODE_POP, 3'h0, 2);
		chk(elem_data, 16'h1234);
		chk(u_stk_mem.mem[15'h0100], 16'h0200);
		u_stk_mem.mem[15'h0100] = 16'h8005;
		u_stk_mem.mem[15'h0004] = 16'habcd;
		index_reg <= 16'hffff;
		go(stk_pkg::OP_READ, stk_pkg::MODE_INDEXED, 3'h0, 3);
		chk(elem_data, 16'habcd);
		chk({1'b0, element_address}, 16'h0004);
		u_stk_mem.mem[15'h0100] = 16'h8300;
		u_stk_mem.mem[15'h0300] = 16'h0120;
		u_stk_mem.mem[15'h0120] = 16'h0040;
		u_stk_mem.mem[15'h0040] = 16'h5a5a;
		ext_model <= 1'b1;
		indirect <= 1'b1;
		go(stk_pkg::OP_READ, stk_pkg::MODE_DIRECT, 3'h0, 4);
		chk(elem_data, 16'h5a5a);
		u_stk_mem.mem[15'h0100] = 16'h8040;
		ext_model <= 1'b0;
		go(stk_pkg::OP_READ, stk_pkg::MODE_DIRECT, 3'h0, 5);
		chk({1'b0, element_address}, 16'h0040);
		u_stk_mem.mem[15'h0100] = 16'h0200;
		u_stk_mem.mem[15'h01ff] = 16'heeee;
		u_stk_mem.mem[15'h01fe] = 16'hdddd;
		ext_model <= 1'b1;
		int_instr <= 1'b1;
		index_reg <= 16'h1111;
		acc_reg <= 16'h2222;
		status_reg <= 16'hfff3;
		pc_reg <= 16'h4444;
		lat <= 4'h1;
		go(stk_pkg::OP_JPR, stk_pkg::MODE_DIRECT, 3'h2, 6);
		chk(u_stk_mem.mem[15'h01fd], 16'h1111);
		chk(u_stk_mem.mem[15'h01fc], 16'h2222);
		chk(u_stk_mem.mem[15'h01fb], 16'hfff3);
		chk(u_stk_mem.mem[15'h01fa], 16'h4444);
		chk(u_stk_mem.mem[15'h0100], 16'h01fa);
		chk(u_stk_mem.mem[15'h01fe], 16'hdddd);
		chk(u_stk_mem.mem[15'h01ff], 16'heeee);
		chk(pc_out, 16'h0101);
		chk(status_out, 16'hfff0);
		chk({15'h0000, int_enable}, 16'h0000);
		index_reg <= 16'h0000;
		acc_reg <= 16'h0000;
		status_reg <= 16'hab00;
		go(stk_pkg::OP_RPR, stk_pkg::MODE_DIRECT, 3'h2, 7);
		chk(pc_out, 16'h4444);
		chk(acc_out, 16'h2222);
		chk(index_out, 16'h1111);
		chk(status_out, 16'habf3);
		chk({15'h0000, int_enable}, 16'h0001);
		chk(u_stk_mem.mem[15'h0100], 16'h0200);
		status_reg <= 16'h0003;
		pc_reg <= 16'h7777;
		go(stk_pkg::OP_JPS, stk_pkg::MODE_DIRECT, 3'h7, 8);
		chk(u_stk_mem.mem[15'h01f9], 16'h0003);
		chk(u_stk_mem.mem[15'h01f8], 16'h7777);
		chk(u_stk_mem.mem[15'h0100], 16'h01f8);
		chk(status_out, 16'h0000);
		chk({15'h0000, int_enable}, 16'h0000);
		pc_reg <= 16'h0000;
		go(stk_pkg::OP_RPS, stk_pkg::MODE_DIRECT, 3'h6, 9);
		chk(pc_out, 16'h7777);
		chk(u_stk_mem.mem[15'h0100], 16'h0200);
		conclude();
	end
endmodule // test_stk_unit
`default_nettype wire
